// file: logic/dbgx_pkg.sv
// debug command executor: shared constants, state and carrier types
// assumes one 40 MHz system clock and a byte stream from the host link
package dbgx_pkg;

  // command bytes from the host
  localparam logic [7:0] CMD_RD_STAT  = 8'h02;
  localparam logic [7:0] CMD_WR_CTL   = 8'h04;
  localparam logic [7:0] CMD_RD_CTL   = 8'h05;
  localparam logic [7:0] CMD_WR_PMEM  = 8'h0a;
  localparam logic [7:0] CMD_RD_PMEM  = 8'h0b;
  localparam logic [7:0] CMD_WR_DMEM  = 8'h0c;
  localparam logic [7:0] CMD_RD_DMEM  = 8'h0d;
  localparam logic [7:0] CMD_CRC      = 8'h0e;
  localparam logic [7:0] CMD_STEP     = 8'h10;
  localparam logic [7:0] CMD_STUFF    = 8'h11;
  localparam logic [7:0] CMD_EXEC     = 8'h12;

  // debug_control field positions
  localparam int CTL_HALT_BIT  = 7;
  localparam int CTL_BREAKPOINT_ENABLE_BIT = 6;
  localparam int CTL_ACK_BIT   = 5;
  localparam int CTL_SPIN_BIT  = 4;
  localparam int CTL_RST_BIT   = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'hf1;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] STAT_RESET  = 8'h00;

  // fixed reply values and crc setup
  localparam logic [7:0]  BYTE_BLANK = 8'hff;
  localparam logic [15:0] CRC_BLANK  = 16'hffff;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_INIT   = 16'hffff;
  localparam logic [2:0]  ARGS_MEM   = 3'h4;
  localparam logic [2:0]  ARGS_ONE   = 3'h1;
  localparam logic [16:0] SIZE_MAX   = 17'h10000;

  // executor states
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_ARG   = 4'b0001,
    S_WDATA = 4'b0010,
    S_RD    = 4'b0011,
    S_MWAIT = 4'b0100,
    S_CRC   = 4'b0101,
    S_CWAIT = 4'b0110,
    S_REPLY = 4'b0111,
    S_EXEC  = 4'b1000,
    S_XLEN  = 4'b1001
  } dbgx_state_e;

  // memory request toward program or data memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic        prog;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dbgx_mem_s;

  // whole executor state
  typedef struct packed {
    dbgx_state_e st;
    logic [7:0]  cmd;
    logic [2:0]  args;
    logic [31:0] argv;
    logic [15:0] addr;
    logic [16:0] left;
    logic [7:0]  ctl;
    logic        brk_seen;
    logic        ack_pend;
    logic [15:0] crc;
    logic [16:0] crc_cnt;
    logic [15:0] reply;
    logic [1:0]  reply_n;
    logic [2:0]  insn_left;
    logic        step;
    logic        stuff;
    logic        exec_v;
    logic [7:0]  op;
    dbgx_mem_s   mem;
  } dbgx_state_s;

endpackage

// file: logic/dbgx_exec.sv
// debug command executor and its reply fifo
// assumes host bytes arrive by valid/ready on clk_sys, memories answer by a one-cycle ack
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dbgx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers and storage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dbgx_exec
  import dbgx_pkg::*;
#(
  parameter int PMEM_BYTES = 65536,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // host byte stream in
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  // host byte stream out
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready,
  // program and data memory
  output dbgx_mem_s       mem,
  input  wire logic       mem_ack,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       flash_unlocked,
  // cpu control
  output logic            debug_halt_mode,
  output logic            cpu_step,
  output logic            cpu_stuff,
  output logic            cpu_exec_valid,
  output logic [7:0]      cpu_op,
  input  wire logic [2:0] insn_len,
  input  wire logic       breakpoint_opcode,
  output logic            breakpoint_spin_out,
  output logic            breakpoint_nop,
  input  wire logic       cpu_low_power_halt,
  // option bit and chip reset
  input  wire logic       read_protect_opt_n,
  output logic            chip_rst_req,
  input  wire logic       chip_rst_done
);
  initial begin
    if (PMEM_BYTES < 1 || PMEM_BYTES > 65536) $error("program memory size out of range");
  end

  localparam logic [16:0] PMEM_N = 17'(PMEM_BYTES);

  dbgx_state_s s_q;
  dbgx_state_s s_d;
  logic        push_v;
  logic [7:0]  push_d;
  logic        fifo_rdy;
  logic        rp_active;
  logic        ok_full;
  logic [7:0]  status;
  logic        brk_hit;

  // one crc-ccitt byte step, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // remaining byte count from a 16-bit size field
  function automatic logic [16:0] size_of(input logic [15:0] sz);
    return (sz == 16'h0000) ? SIZE_MAX : {1'b0, sz};
  endfunction

  assign rp_active = !read_protect_opt_n;
  assign ok_full   = s_q.ctl[CTL_HALT_BIT] && !rp_active;
  assign brk_hit   = breakpoint_opcode && s_q.ctl[CTL_BREAKPOINT_ENABLE_BIT];
  // status byte, low five bits tied off
  assign status    = {s_q.ctl[CTL_HALT_BIT] || s_q.brk_seen,
                      cpu_low_power_halt,
                      rp_active,
                      5'h00};

  // host can send only while a byte is expected
  assign rx_ready = (s_q.st == S_IDLE && !s_q.ack_pend) || s_q.st == S_ARG
                 || s_q.st == S_WDATA || s_q.st == S_EXEC;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d        = s_q;
    push_v     = 1'b0;
    push_d     = BYTE_BLANK;
    s_d.step   = 1'b0;
    s_d.stuff  = 1'b0;
    s_d.exec_v = 1'b0;
    s_d.mem.req = 1'b0;

    // breakpoint side effects; the set wins over a control write below
    if (brk_hit && !s_q.ctl[CTL_SPIN_BIT]) begin
      s_d.ctl[CTL_HALT_BIT] = 1'b1;
    end
    if (brk_hit && s_q.ctl[CTL_ACK_BIT]) begin
      s_d.ack_pend = 1'b1;
    end
    // self reset bit drops once the chip reset finishes, unless a control write lands in the same cycle
    if (chip_rst_done) begin
      s_d.ctl[CTL_RST_BIT] = 1'b0;
    end

    unique case (s_q.st)
      S_IDLE: begin
        if (s_q.ack_pend) begin
          // acknowledge waits for fifo room, commands wait behind it
          if (fifo_rdy) begin
            push_v       = 1'b1;
            s_d.ack_pend = brk_hit && s_q.ctl[CTL_ACK_BIT];
          end
        end else if (rx_valid) begin
          s_d.cmd  = rx_data;
          s_d.argv = '0;
          unique case (rx_data)
            CMD_RD_STAT: begin
              s_d.reply   = {status, 8'h00};
              s_d.reply_n = 2'd1;
              s_d.st      = S_REPLY;
            end
            CMD_RD_CTL: begin
              s_d.reply   = {s_q.ctl, 8'h00};
              s_d.reply_n = 2'd1;
              s_d.st      = S_REPLY;
            end
            CMD_WR_CTL, CMD_STUFF: begin
              s_d.args = ARGS_ONE;
              s_d.st   = S_ARG;
            end
            CMD_WR_PMEM, CMD_RD_PMEM, CMD_WR_DMEM, CMD_RD_DMEM: begin
              s_d.args = ARGS_MEM;
              s_d.st   = S_ARG;
            end
            CMD_CRC: begin
              s_d.crc     = CRC_INIT;
              s_d.crc_cnt = '0;
              s_d.addr    = '0;
              if (s_q.ctl[CTL_HALT_BIT]) begin
                s_d.st = S_CRC;
              end else begin
                s_d.reply   = CRC_BLANK;
                s_d.reply_n = 2'd2;
                s_d.st      = S_REPLY;
              end
            end
            CMD_STEP: begin
              s_d.step = ok_full;
            end
            CMD_EXEC: begin
              s_d.st = S_EXEC;
            end
            default: begin
              s_d.st = S_IDLE;
            end
          endcase
        end
      end
      S_ARG: begin
        if (rx_valid) begin
          s_d.argv = {s_q.argv[23:0], rx_data};
          s_d.args = s_q.args - 3'd1;
          if (s_q.args == 3'd1) begin
            s_d.st = S_IDLE;
            if (s_q.cmd == CMD_WR_CTL) begin
              // reserved bits kept at zero; protection keeps the halt bit up
              s_d.ctl = rx_data & CTL_WR_MASK;
              if (rp_active && s_q.ctl[CTL_HALT_BIT]) begin
                s_d.ctl[CTL_HALT_BIT] = 1'b1;
              end
              if (brk_hit && !s_q.ctl[CTL_SPIN_BIT]) begin
                s_d.ctl[CTL_HALT_BIT] = 1'b1;
              end
              s_d.brk_seen = brk_hit;
            end else if (s_q.cmd == CMD_STUFF) begin
              s_d.op    = rx_data;
              s_d.stuff = ok_full;
            end else begin
              s_d.addr = s_q.argv[23:8];
              s_d.left = size_of({s_q.argv[7:0], rx_data});
              s_d.st   = (s_q.cmd == CMD_WR_PMEM || s_q.cmd == CMD_WR_DMEM) ? S_WDATA : S_RD;
            end
          end
        end
      end
      S_WDATA: begin
        if (rx_valid) begin
          s_d.left = s_q.left - 17'd1;
          s_d.addr = s_q.addr + 16'd1;
          s_d.st   = (s_q.left == 17'd1) ? S_IDLE : S_WDATA;
          // write only when allowed; else the byte is swallowed
          if (ok_full && (s_q.cmd == CMD_WR_DMEM || flash_unlocked)) begin
            s_d.mem = '{req: 1'b1, we: 1'b1, prog: s_q.cmd == CMD_WR_PMEM,
                        addr: s_q.addr, wdata: rx_data};
            s_d.st  = S_MWAIT;
          end
        end
      end
      S_RD: begin
        if (fifo_rdy) begin
          if ((s_q.cmd == CMD_RD_PMEM) ? ok_full : s_q.ctl[CTL_HALT_BIT]) begin
            s_d.mem = '{req: 1'b1, we: 1'b0, prog: s_q.cmd == CMD_RD_PMEM,
                        addr: s_q.addr, wdata: 8'h00};
            s_d.st  = S_MWAIT;
          end else begin
            push_v   = 1'b1;
            s_d.left = s_q.left - 17'd1;
            s_d.addr = s_q.addr + 16'd1;
            s_d.st   = (s_q.left == 17'd1) ? S_IDLE : S_RD;
          end
        end
      end
      S_MWAIT: begin
        if (mem_ack) begin
          if (!s_q.mem.we) begin
            // room was checked before the request; only this path fills
            push_v   = 1'b1;
            push_d   = mem_rdata;
            s_d.left = s_q.left - 17'd1;
            s_d.addr = s_q.addr + 16'd1;
            s_d.st   = (s_q.left == 17'd1) ? S_IDLE : S_RD;
          end else begin
            s_d.st = (s_q.left == 17'd0) ? S_IDLE : S_WDATA;
          end
        end
      end
      S_CRC: begin
        s_d.mem = '{req: 1'b1, we: 1'b0, prog: 1'b1, addr: s_q.addr, wdata: 8'h00};
        s_d.st  = S_CWAIT;
      end
      S_CWAIT: begin
        if (mem_ack) begin
          s_d.crc     = crc_byte(s_q.crc, mem_rdata);
          s_d.crc_cnt = s_q.crc_cnt + 17'd1;
          s_d.addr    = s_q.addr + 16'd1;
          s_d.st      = S_CRC;
          if (s_q.crc_cnt == PMEM_N - 17'd1) begin
            s_d.reply   = crc_byte(s_q.crc, mem_rdata);
            s_d.reply_n = 2'd2;
            s_d.st      = S_REPLY;
          end
        end
      end
      S_REPLY: begin
        if (fifo_rdy) begin
          push_v      = 1'b1;
          push_d      = s_q.reply[15:8];
          s_d.reply   = {s_q.reply[7:0], 8'h00};
          s_d.reply_n = s_q.reply_n - 2'd1;
          s_d.st      = (s_q.reply_n == 2'd1) ? S_IDLE : S_REPLY;
        end
      end
      S_EXEC: begin
        if (rx_valid) begin
          s_d.op     = rx_data;
          s_d.exec_v = ok_full;
          s_d.st     = S_XLEN;
          if (s_q.insn_left != 3'd0) begin
            s_d.insn_left = s_q.insn_left - 3'd1;
            s_d.st        = (s_q.insn_left == 3'd1) ? S_IDLE : S_EXEC;
          end
        end
      end
      S_XLEN: begin
        // cpu decodes the first byte held on cpu_op
        s_d.insn_left = (insn_len > 3'd1) ? insn_len - 3'd1 : 3'd0;
        s_d.st        = (insn_len > 3'd1) ? S_EXEC : S_IDLE;
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase

    // breakpoint since the last control write
    if (brk_hit) begin
      s_d.brk_seen = 1'b1;
    end
  end

  // state register; the debugger is not touched by the chip reset it issues
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply bytes drain toward the host through a small fifo
  dbgx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (push_v),
    .in_data   (push_d),
    .in_ready  (fifo_rdy),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  // outputs straight from state
  assign mem                 = s_q.mem;
  assign debug_halt_mode     = s_q.ctl[CTL_HALT_BIT];
  assign cpu_step            = s_q.step;
  assign cpu_stuff           = s_q.stuff;
  assign cpu_exec_valid      = s_q.exec_v;
  assign cpu_op              = s_q.op;
  assign breakpoint_spin_out = s_q.ctl[CTL_BREAKPOINT_ENABLE_BIT] && s_q.ctl[CTL_SPIN_BIT];
  assign breakpoint_nop      = !s_q.ctl[CTL_BREAKPOINT_ENABLE_BIT];
  assign chip_rst_req        = s_q.ctl[CTL_RST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence ctl_cmd_s;
    s_q.st == S_IDLE && !s_q.ack_pend && rx_valid && rx_data == CMD_WR_CTL;
  endsequence

  halt_on_brk_a: assert property (brk_hit && !s_q.ctl[CTL_SPIN_BIT] |=> debug_halt_mode)
    else $error("breakpoint did not halt");
  spin_no_halt_a: assert property (brk_hit && s_q.ctl[CTL_SPIN_BIT] && !debug_halt_mode
      && !(s_q.st == S_ARG && s_q.cmd == CMD_WR_CTL) |=> !debug_halt_mode)
    else $error("spinning breakpoint halted");
  protect_halt_a: assert property (rp_active && debug_halt_mode |=> debug_halt_mode)
    else $error("halt cleared under protection");
  status_low_a: assert property (status[4:0] == 5'h00 && status[5] == rp_active)
    else $error("status low bits not zero");
  step_gate_a: assert property (cpu_step |-> $past(ok_full))
    else $error("step while not allowed");
  prot_write_a: assert property (mem.req && mem.we |-> $past(ok_full))
    else $error("memory write while not allowed");
  ctl_load_a: assert property (ctl_cmd_s ##1 (rx_valid && !brk_hit && !rp_active
      && !chip_rst_done) |=> s_q.ctl == ($past(rx_data) & CTL_WR_MASK))
    else $error("control byte not loaded");
  crc_blank_a: assert property (s_q.st == S_IDLE && !s_q.ack_pend && rx_valid
      && rx_data == CMD_CRC && !debug_halt_mode |=> s_q.reply == CRC_BLANK)
    else $error("crc not blank while running");
  addr_step_a: assert property (mem_ack && s_q.st == S_MWAIT && !s_q.mem.we
      |=> s_q.addr == $past(s_q.addr) + 16'd1)
    else $error("address did not step");
  rst_clear_a: assert property (chip_rst_done |=> !chip_rst_req)
    else $error("self reset bit not cleared");
endmodule

// file: test/dbgx_host_model.sv
// host debugger model: sends command bytes, collects reply bytes
// assumes the bench calls send from just after a rising edge of clk_sys
`timescale 1ns/1ps

module dbgx_host_model (
  // clock and mode
  input  wire logic       clk_sys,
  input  wire logic       slow,
  // byte stream toward the executor
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  // reply stream from the executor
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            hung
);
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
    hung     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold the byte until taken; address and size go high byte first
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_valid = 1'b1;
    rx_data  = b;
    @(posedge clk_sys);
    while (!rx_ready && n < 5000) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 5000) hung = 1'b1;
    #1;
  endtask

  // released line shows the inverse, not a stale byte
  task automatic idle();
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // a slow host stalls every other cycle
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    #1 tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

// file: test/dbgx_exec_bench.sv
// self-checking bench for the debug command executor
// assumes a one-cycle memory answer and a 16-byte program memory
`timescale 1ns/1ps

module dbgx_exec_bench;
  import dbgx_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, slow = 1'b0, hung;
  logic rx_valid, rx_ready, tx_valid, tx_ready, mem_ack = 1'b0, unl = 1'b0;
  logic [7:0] rx_data, tx_data, mem_rdata = 8'h00, cpu_op;
  logic halt, stp, stf, exv, bp = 1'b0, lp = 1'b0, opt_n = 1'b1, rreq, rdone = 1'b0;
  logic spin, nop;
  logic [2:0] ilen = 3'h2;
  dbgx_mem_s mem;
  int n_fail = 0, checks = 0, n_wr = 0, n_stp = 0, n_stf = 0, n_ex = 0;

  always #12.5 clk_sys = ~clk_sys;

  dbgx_exec #(.PMEM_BYTES(16), .FIFO_DEPTH(4)) dbgx_exec_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .flash_unlocked(unl),
    .debug_halt_mode(halt), .cpu_step(stp), .cpu_stuff(stf), .cpu_exec_valid(exv),
    .cpu_op(cpu_op), .insn_len(ilen), .breakpoint_opcode(bp), .breakpoint_spin_out(spin),
    .breakpoint_nop(nop), .cpu_low_power_halt(lp), .read_protect_opt_n(opt_n),
    .chip_rst_req(rreq), .chip_rst_done(rdone));

  dbgx_host_model dbgx_host_model_inst (
    .clk_sys(clk_sys), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .hung(hung));

  ////////////////////////////////////////////////////////////////////////////
  // memory answers next cycle; contents are address xor 5a
  always @(posedge clk_sys) begin
    mem_ack   <= mem.req;
    mem_rdata <= mem.addr[7:0] ^ 8'h5a;
    if (mem.req && mem.we) n_wr++;
    if (stp) n_stp++;
    if (stf) n_stf++;
    if (exv) n_ex++;
  end

  always @(posedge hung) begin
    n_fail++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmd(input logic [7:0] b[$]);
    foreach (b[i]) dbgx_host_model_inst.send(b[i]);
    dbgx_host_model_inst.idle();
  endtask

  // bounded wait for one reply byte; crc may take long
  task automatic rep(input logic [7:0] e);
    int n;
    // look one step after the edge so the next drive never races the design
    for (n = 0; n < 3000 && dbgx_host_model_inst.got.size() == 0; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n >= 3000) begin
      n_fail++;
      stop_test();
    end else begin
      chk(dbgx_host_model_inst.got.pop_front(), e);
    end
  endtask

  // let a request launched by the last host byte reach the memory side
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    c = 16'hffff;
    for (int a = 0; a < 16; a++) begin
      c = c ^ {a[7:0] ^ 8'h5a, 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cmd('{8'h02}); rep(8'h00);
    cmd('{8'h05}); rep(8'h00);
    chk(nop, 1'b1);
  endtask

  task automatic t_status();
    lp = 1'b1;
    opt_n = 1'b0;
    cmd('{8'h02}); rep(8'h60);
    lp = 1'b0;
    opt_n = 1'b1;
  endtask

  task automatic t_rst_halt();
    cmd('{8'h04, 8'h81}); cmd('{8'h05}); rep(8'h81);
    chk(rreq, 1'b1);
    rdone = 1'b1;
    @(posedge clk_sys) #1 rdone = 1'b0;
    cmd('{8'h05}); rep(8'h80);
    chk(halt, 1'b1);
    cmd('{8'h02}); rep(8'h80);
  endtask

  task automatic t_mem();
    int w;
    w = n_wr;
    cmd('{8'h0b, 8'h00, 8'hff, 8'h00, 8'h02}); rep(8'ha5); rep(8'h5a);
    cmd('{8'h0c, 8'h00, 8'h10, 8'h00, 8'h01, 8'h33}); settle(); chk(n_wr - w, 1);
    cmd('{8'h0a, 8'h00, 8'h10, 8'h00, 8'h01, 8'h33}); settle(); chk(n_wr - w, 1);
    unl = 1'b1;
    cmd('{8'h0a, 8'h00, 8'h10, 8'h00, 8'h01, 8'h44}); settle(); chk(n_wr - w, 2);
    chk({7'h00, mem.prog, mem.wdata}, 16'h0144);
    unl = 1'b0;
    opt_n = 1'b0;
    cmd('{8'h0b, 8'h00, 8'h01, 8'h00, 8'h01}); rep(8'hff);
    cmd('{8'h0d, 8'h00, 8'h03, 8'h00, 8'h01}); rep(8'h59);
    cmd('{8'h0c, 8'h00, 8'h10, 8'h00, 8'h01, 8'h33}); settle(); chk(n_wr - w, 2);
    opt_n = 1'b1;
  endtask

  task automatic t_cpu();
    cmd('{8'h10}); cmd('{8'h11, 8'h3c}); cmd('{8'h12, 8'h21, 8'h44});
    cmd('{8'h02}); rep(8'h80);
    chk(n_stp, 1);
    chk(n_stf, 1);
    chk(cpu_op, 8'h44);
    chk(n_ex, 2);
    ilen = 3'h1;
    cmd('{8'h12, 8'h07}); cmd('{8'h02}); rep(8'h80);
    chk(n_ex, 3);
    chk(cpu_op, 8'h07);
    ilen = 3'h2;
    opt_n = 1'b0;
    cmd('{8'h10}); cmd('{8'h04, 8'h00}); cmd('{8'h05}); rep(8'h80);
    chk(n_stp, 1);
    opt_n = 1'b1;
  endtask

  task automatic t_crc();
    logic [15:0] e;
    e = crc_exp();
    cmd('{8'h0e}); rep(e[15:8]); rep(e[7:0]);
    cmd('{8'h04, 8'h00}); cmd('{8'h0e}); rep(8'hff); rep(8'hff);
    chk(halt, 1'b0);
    cmd('{8'h04, 8'h41}); cmd('{8'h05}); rep(8'h41);
    chk(rreq, 1'b1);
    rdone = 1'b1;
    @(posedge clk_sys) #1 rdone = 1'b0;
    cmd('{8'h05}); rep(8'h40);
    chk(halt, 1'b0);
  endtask

  task automatic t_brk();
    slow = 1'b1;
    cmd('{8'h04, 8'h60}); cmd('{8'h05}); rep(8'h60);
    chk(nop, 1'b0);
    bp = 1'b1;
    @(posedge clk_sys) #1 bp = 1'b0;
    rep(8'hff);
    chk(halt, 1'b1);
    cmd('{8'h02}); rep(8'h80);
    cmd('{8'h04, 8'h50}); chk(spin, 1'b1);
    bp = 1'b1;
    @(posedge clk_sys) #1 bp = 1'b0;
    cmd('{8'h02}); rep(8'h80);
    chk(halt, 1'b0);
    slow = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_reset();
    t_status();
    t_rst_halt();
    t_mem();
    t_cpu();
    t_crc();
    t_brk();
    stop_test();
  end
endmodule
